// ==== mrs_pin_ctrl.sv ====
// Per-pin drive and input gating for one group of multiplexed pins.
// Assumes drive_en and in_en are registered controls from the sequencer.
`timescale 1ns/10ps
module mrs_pin_ctrl
  import mrs_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Controls
  input wire logic drive_en,
  input wire logic in_en,
  // Core side
  input wire logic [W-1:0] core_out,
  input wire logic [W-1:0] core_oe,
  output logic [W-1:0] core_in_q,
  // Pin side
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out_q,
  output logic [W-1:0] pin_oe_q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      wire drive_w = drive_en & core_oe[i];
      // Gated input keeps a floating pin from reaching the core
      wire in_w = in_en & pin_in[i];
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          pin_oe_q[i] <= 1'b0;
          pin_out_q[i] <= 1'b0;
          core_in_q[i] <= 1'b0;
        end else begin
          pin_oe_q[i] <= drive_w;
          pin_out_q[i] <= core_out[i];
          core_in_q[i] <= in_w;
        end
      end
    end
  endgenerate
endmodule : mrs_pin_ctrl

// ==== mrs_pkg.sv ====
// Constants, register map and state type of the chip reset sequencer.
// Assumes a single 50 MHz clock and a synchronous active-low block reset.
// Overview of operation
// - The core is held in reset for as long as the chip reset pin is seen low.
// - On release the program counter is loaded with the reset vector and fetch starts there.
// - In boot mode the loaded vector is the boot program start address.
// - Outside boot mode the program counter holds zero after reset exit.
// - The status word reads zero after reset except its three backup bits, which keep old values.
// - The condition bit register, flag included, is cleared after reset exit.
// - RAM is undefined after power-on but kept across a reset while the backup supply is good.
// - Every pin that is an input at reset is high impedance during and after reset.
// - In single-chip mode multiplexed pins are port inputs, high impedance in and after reset.
// - In extension mode address and data pins float in reset; after reset exit each group is driven while the core enables it.
// - The CAN receive pin is input only and never driven.
// - The test pins are reset only by the test reset pin and float while it is low.
// - Port input buffers stay disabled until software sets the port input enable bit.
package mrs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_PINS = 19;
  localparam int DBUS_PINS = 16;

  localparam logic [31:0] BOOT_VECTOR = 32'h8000_0000;
  localparam logic [31:0] PLAIN_VECTOR = 32'h0000_0000;
  localparam logic [31:0] PSW_RESET = 32'h0000_0000;
  localparam logic [31:0] PSW_KEEP_MASK = 32'h0000_C100;
  localparam logic [31:0] CBR_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_VECTOR = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PSW = 8'h0C;

  // Field positions
  localparam int CTRL_PORT_IN_EN = 0;
  localparam int STAT_IN_RESET = 0;
  localparam int STAT_BOOT = 1;
  localparam int STAT_EXT = 2;
  localparam int STAT_RAM_VALID = 3;
  localparam int STAT_PLL_WAIT = 4;

  typedef enum logic [1:0] {
    ST_POWER,
    ST_HOLD,
    ST_LOAD,
    ST_RUN
  } mrs_state_type;
endpackage : mrs_pkg

// ==== mrs_reset_seq.sv ====
// Chip reset sequencer: holds the core in reset, loads the reset vector,
// presets processor control registers and controls pin states around reset.
// Assumes mode straps are stable while the reset pin is low and that the
// outside keeps the pin low until the clock multiplier is locked.
`timescale 1ns/10ps
module mrs_reset_seq
  import mrs_pkg::*;
(
  // Clock and block reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Reset pin, clock lock, mode straps, supply
  input wire logic reset_pin_n,
  input wire logic pll_locked,
  input wire logic boot_mode_pin,
  input wire logic ext_mode_pin,
  input wire logic backup_supply_ok,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_q,
  // Core control
  output logic cpu_reset_n_q,
  output logic pc_load_q,
  output logic [31:0] pc_value_q,
  output logic fetch_start_q,
  output logic [31:0] psw_init_q,
  output logic [31:0] psw_keep_q,
  output logic [31:0] cbr_init_q,
  output logic ram_valid_q,
  input wire logic [31:0] psw_now,
  // Address pins
  input wire logic [ADDR_PINS-1:0] cpu_addr_out,
  input wire logic cpu_addr_oe,
  input wire logic [ADDR_PINS-1:0] addr_pin_in,
  output logic [ADDR_PINS-1:0] addr_pin_out_q,
  output logic [ADDR_PINS-1:0] addr_pin_oe_q,
  output logic [ADDR_PINS-1:0] addr_port_in_q,
  // Data bus pins
  input wire logic [DBUS_PINS-1:0] cpu_data_out,
  input wire logic cpu_data_oe,
  input wire logic [DBUS_PINS-1:0] data_pin_in,
  output logic [DBUS_PINS-1:0] data_pin_out_q,
  output logic [DBUS_PINS-1:0] data_pin_oe_q,
  output logic [DBUS_PINS-1:0] data_port_in_q,
  // CAN receive pin
  input wire logic can_receive_pin,
  output logic can_rx_q,
  output logic can_rx_oe_q,
  // Test port pins
  input wire logic test_reset_pin_n,
  input wire logic tap_tdo,
  input wire logic tap_tdo_en,
  output logic test_tdo_q,
  output logic test_tdo_oe_q,
  // Port input enable
  output logic port_in_en_q
);
  mrs_state_type state_q;
  mrs_state_type state_d;
  logic pin_sync;
  logic boot_q;
  logic ext_q;
  logic run_q;
  logic addr_drive_q;
  logic data_drive_q;

  mrs_sync u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_n(reset_pin_n),
    .pin_sync_q(pin_sync)
  );

  // Sequencer. Power-on waits for lock as a safety net in case the pin
  // is released early; a short pin pulse still gives a full reset.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POWER: begin
        if (pin_sync && pll_locked) begin
          state_d = ST_LOAD;
        end
      end
      ST_HOLD: begin
        if (pin_sync) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        state_d = pin_sync ? ST_RUN : ST_HOLD;
      end
      ST_RUN: begin
        if (!pin_sync) begin
          state_d = ST_HOLD;
        end
      end
      default: begin
        state_d = ST_POWER;
      end
    endcase
  end

  wire hold_w = (state_d == ST_POWER) || (state_d == ST_HOLD);
  wire load_w = (state_d == ST_LOAD);
  wire run_w = (state_d == ST_RUN);
  wire [31:0] vector_w = boot_q ? BOOT_VECTOR : PLAIN_VECTOR;
  wire strap_w = (state_q == ST_POWER) || (state_q == ST_HOLD);
  // Backup bits keep whatever the core held; everything else is cleared
  wire [31:0] psw_w = (psw_now & PSW_KEEP_MASK) | (PSW_RESET & ~PSW_KEEP_MASK);
  wire ram_lost_w = !backup_supply_ok && hold_w;
  wire addr_drive_w = run_w && ext_q && cpu_addr_oe;
  wire data_drive_w = run_w && ext_q && cpu_data_oe;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= ST_POWER;
      cpu_reset_n_q <= 1'b0;
      pc_load_q <= 1'b0;
      fetch_start_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cpu_reset_n_q <= !hold_w;
      pc_load_q <= load_w;
      fetch_start_q <= pc_load_q && run_w;
      run_q <= run_w;
    end
  end

  // Straps are caught while the pin holds the device in reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      boot_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (strap_w) begin
      boot_q <= boot_mode_pin;
      ext_q <= ext_mode_pin;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pc_value_q <= PLAIN_VECTOR;
      psw_init_q <= PSW_RESET;
      psw_keep_q <= PSW_KEEP_MASK;
      cbr_init_q <= CBR_RESET;
    end else if (load_w) begin
      pc_value_q <= vector_w;
      psw_init_q <= psw_w;
      psw_keep_q <= PSW_KEEP_MASK;
      cbr_init_q <= CBR_RESET;
    end
  end

  // Power-on loses RAM; a pin reset keeps it while the backup supply holds
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ram_valid_q <= 1'b0;
    end else if (ram_lost_w) begin
      ram_valid_q <= 1'b0;
    end else if (run_w) begin
      ram_valid_q <= 1'b1;
    end
  end

  // Pin drive is allowed only after reset exit and only in extension mode
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      addr_drive_q <= 1'b0;
      data_drive_q <= 1'b0;
    end else begin
      addr_drive_q <= addr_drive_w;
      data_drive_q <= data_drive_w;
    end
  end

  mrs_pin_ctrl #(
    .W(ADDR_PINS)
  ) u_addr_pins (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .drive_en(addr_drive_q),
    .in_en(port_in_en_q),
    .core_out(cpu_addr_out),
    .core_oe({ADDR_PINS{1'b1}}),
    .core_in_q(addr_port_in_q),
    .pin_in(addr_pin_in),
    .pin_out_q(addr_pin_out_q),
    .pin_oe_q(addr_pin_oe_q)
  );

  mrs_pin_ctrl #(
    .W(DBUS_PINS)
  ) u_data_pins (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .drive_en(data_drive_q),
    .in_en(port_in_en_q),
    .core_out(cpu_data_out),
    .core_oe({DBUS_PINS{1'b1}}),
    .core_in_q(data_port_in_q),
    .pin_in(data_pin_in),
    .pin_out_q(data_pin_out_q),
    .pin_oe_q(data_pin_oe_q)
  );

  // CAN receive is input only; its enable never rises
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      can_rx_q <= 1'b0;
      can_rx_oe_q <= 1'b0;
    end else begin
      can_rx_q <= can_receive_pin & port_in_en_q;
      can_rx_oe_q <= 1'b0;
    end
  end

  // Test pins ignore the chip reset; only the test reset floats them
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      test_tdo_q <= 1'b0;
      test_tdo_oe_q <= 1'b0;
    end else begin
      test_tdo_q <= tap_tdo;
      test_tdo_oe_q <= test_reset_pin_n && tap_tdo_en;
    end
  end

  // Register port
  wire sel_ctrl = (reg_addr == REG_CTRL);
  wire sel_status = (reg_addr == REG_STATUS);
  wire sel_vector = (reg_addr == REG_VECTOR);
  wire sel_psw = (reg_addr == REG_PSW);
  wire ctrl_wr = reg_wr && sel_ctrl;
  wire [31:0] status_w = {27'h000_0000, (state_q == ST_POWER), ram_valid_q, ext_q, boot_q,
    !cpu_reset_n_q};
  wire [31:0] ctrl_w = {31'h0000_0000, port_in_en_q};
  wire [31:0] rdata_w = sel_ctrl ? ctrl_w :
    sel_status ? status_w :
    sel_vector ? pc_value_q :
    sel_psw ? psw_init_q : ZERO_WORD;

  // Enable is cleared by every chip reset so inputs start disabled
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      port_in_en_q <= 1'b0;
    end else if (hold_w) begin
      port_in_en_q <= 1'b0;
    end else if (ctrl_wr) begin
      port_in_en_q <= reg_wdata[CTRL_PORT_IN_EN];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata_q <= ZERO_WORD;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_w;
    end else begin
      reg_rdata_q <= ZERO_WORD;
    end
  end

  hold_reset_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !pin_sync |=> !cpu_reset_n_q)
    else $error("core left out of reset while pin low");

  load_then_fetch_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    pc_load_q && pin_sync |=> fetch_start_q && !pc_load_q && cpu_reset_n_q)
    else $error("fetch did not follow vector load");

  boot_vector_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    pc_load_q && boot_q |-> pc_value_q == BOOT_VECTOR)
    else $error("boot vector wrong");

  plain_vector_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    pc_load_q && !boot_q |-> pc_value_q == PLAIN_VECTOR)
    else $error("plain vector not zero");

  psw_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(pc_load_q) |-> (psw_init_q & ~psw_keep_q) == PSW_RESET &&
      psw_keep_q == PSW_KEEP_MASK)
    else $error("status word not cleared");

  cbr_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    pc_load_q |-> cbr_init_q == CBR_RESET)
    else $error("condition register not cleared");

  ram_lost_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !backup_supply_ok && !pin_sync |=> ##1 !ram_valid_q)
    else $error("RAM kept without backup supply");

  addr_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !cpu_reset_n_q |=> ##1 addr_pin_oe_q == '0)
    else $error("address pins driven in reset");

  data_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !cpu_reset_n_q |=> ##1 data_pin_oe_q == '0)
    else $error("data pins driven in reset");

  single_chip_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !ext_q [*3] |-> addr_pin_oe_q == '0 && data_pin_oe_q == '0)
    else $error("pin driven in single-chip mode");

  can_input_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !can_rx_oe_q)
    else $error("CAN receive pin driven");

  test_float_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !test_reset_pin_n |=> !test_tdo_oe_q)
    else $error("test pin driven in test reset");

  port_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !port_in_en_q |=> addr_port_in_q == '0 && data_port_in_q == '0)
    else $error("port input passed while disabled");

  fetch_run_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    fetch_start_q |-> run_q && cpu_reset_n_q)
    else $error("fetch started outside run");

  hold_release_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    state_q == ST_HOLD && pin_sync |=> cpu_reset_n_q && pc_load_q)
    else $error("pin release did not load the vector");

  rise_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(cpu_reset_n_q) |-> pc_load_q)
    else $error("core and vector load left reset apart");

  vector_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    run_q && $past(run_q) |-> $stable(pc_value_q))
    else $error("vector changed while running");

  drive_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !ext_q |-> !addr_drive_q && !data_drive_q)
    else $error("pin drive armed in single-chip mode");

  port_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !cpu_reset_n_q |-> !port_in_en_q)
    else $error("port input enabled in reset");

  test_follow_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    test_reset_pin_n && tap_tdo_en |=> test_tdo_oe_q)
    else $error("test pin enable lost outside test reset");
endmodule : mrs_reset_seq

// ==== mrs_reset_seq_tb.sv ====
// Self-checking bench for the chip reset sequencer.
// Assumes the reset source model drives the pin; the bench drives straps and registers.
`timescale 1ns/10ps
module mrs_reset_seq_tb;
  import mrs_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, kick = 1'b0, boot_mode_pin = 1'b0, ext_mode_pin = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, test_reset_pin_n = 1'b0, tap_tdo_en = 1'b1;
  logic backup_supply_ok = 1'b1, cpu_data_oe = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
  logic [31:0] psw_now = 32'hFFFF_FFFF;
  logic [ADDR_PINS-1:0] addr_pin_in = 19'h0_5A5A;
  logic [DBUS_PINS-1:0] data_pin_in = 16'hC3A5;
  logic reset_pin_n, pll_locked, cpu_reset_n_q, pc_load_q, fetch_start_q, ram_valid_q;
  logic can_rx_q, can_rx_oe_q, test_tdo_q, test_tdo_oe_q, port_in_en_q;
  logic [DATA_W-1:0] reg_rdata_q;
  logic [31:0] pc_value_q, psw_init_q, psw_keep_q, cbr_init_q;
  logic [ADDR_PINS-1:0] addr_pin_out_q, addr_pin_oe_q, addr_port_in_q;
  logic [DBUS_PINS-1:0] data_pin_out_q, data_pin_oe_q, data_port_in_q;
  int err_count = 0, checks = 0;

  always #10 ref_clk = ~ref_clk;

  mrs_reset_src mrs_reset_src_inst (.ref_clk, .kick, .reset_pin_n, .pll_locked);

  mrs_reset_seq mrs_reset_seq_inst (
    .ref_clk, .resetn, .reset_pin_n, .pll_locked, .boot_mode_pin, .ext_mode_pin,
    .backup_supply_ok, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .cpu_reset_n_q, .pc_load_q, .pc_value_q, .fetch_start_q, .psw_init_q, .psw_keep_q,
    .cbr_init_q, .ram_valid_q, .psw_now, .cpu_addr_out(19'h1_2345), .cpu_addr_oe(1'b1),
    .addr_pin_in, .addr_pin_out_q, .addr_pin_oe_q, .addr_port_in_q,
    .cpu_data_out(16'h3C96), .cpu_data_oe, .data_pin_in, .data_pin_out_q,
    .data_pin_oe_q, .data_port_in_q, .can_receive_pin(1'b1), .can_rx_q, .can_rx_oe_q,
    .test_reset_pin_n, .tap_tdo(1'b1), .tap_tdo_en, .test_tdo_q, .test_tdo_oe_q,
    .port_in_en_q
  );

  task automatic stop_test;
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask : rd

  // Bounded wait on the core reset; a timeout shows up as a mismatch
  task automatic wait_core(input logic lvl);
    for (int i = 0; i < 200 && cpu_reset_n_q !== lvl; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(32'(cpu_reset_n_q), 32'(lvl));
  endtask : wait_core

  task automatic t_power;
    chk(32'(cpu_reset_n_q), 32'h0000_0000);
    chk(32'(addr_pin_oe_q), 32'h0000_0000);
    chk(32'(data_pin_oe_q), 32'h0000_0000);
    chk(32'(can_rx_oe_q), 32'h0000_0000);
    chk(32'(test_tdo_oe_q), 32'h0000_0000);
    rd(REG_STATUS, 32'h0000_0011);
    wait_core(1'b1);
    chk(32'(pc_load_q), 32'h0000_0001);
    chk(pc_value_q, PLAIN_VECTOR);
    chk(cbr_init_q, CBR_RESET);
    chk(psw_init_q & ~PSW_KEEP_MASK, PSW_RESET);
    chk(psw_keep_q, PSW_KEEP_MASK);
    tick(1);
    chk(32'(fetch_start_q), 32'h0000_0001);
    tick(3);
    chk(32'(addr_pin_oe_q), 32'h0000_0000);
    chk(32'(port_in_en_q), 32'h0000_0000);
    chk(32'(data_port_in_q), 32'h0000_0000);
  endtask : t_power

  task automatic t_regs;
    wr(REG_CTRL, 32'h0000_0001);
    tick(2);
    chk(32'(port_in_en_q), 32'h0000_0001);
    chk(32'(data_port_in_q), 32'(data_pin_in));
    chk(32'(addr_port_in_q), 32'(addr_pin_in));
    chk(32'(can_rx_q), 32'h0000_0001);
    rd(REG_STATUS, 32'h0000_0008);
    rd(REG_VECTOR, PLAIN_VECTOR);
    rd(REG_PSW, PSW_KEEP_MASK);
    rd(8'h40, 32'h0000_0000);
  endtask : t_regs

  task automatic t_ext_boot;
    @(posedge ref_clk);
    test_reset_pin_n <= 1'b1;
    boot_mode_pin <= 1'b1;
    ext_mode_pin <= 1'b1;
    tick(3);
    chk(32'(test_tdo_oe_q), 32'h0000_0001);
    @(posedge ref_clk);
    kick <= 1'b1;
    @(posedge ref_clk);
    kick <= 1'b0;
    wait_core(1'b0);
    chk(32'(addr_pin_oe_q), 32'h0000_0000);
    chk(32'(test_tdo_oe_q), 32'h0000_0001);
    tick(1);
    chk(32'(cpu_reset_n_q), 32'h0000_0000);
    wait_core(1'b1);
    chk(pc_value_q, BOOT_VECTOR);
    chk(32'(ram_valid_q), 32'h0000_0001);
    tick(3);
    chk(32'(addr_pin_oe_q), 32'({ADDR_PINS{1'b1}}));
    chk(32'(data_pin_oe_q), 32'h0000_0000);
    chk(32'(port_in_en_q), 32'h0000_0000);
    chk(32'(can_rx_oe_q), 32'h0000_0000);
    chk(32'(addr_pin_out_q), 32'h0001_2345);
    chk(32'(data_pin_out_q), 32'h0000_3C96);
    chk(32'(test_tdo_q), 32'h0000_0001);
    rd(REG_VECTOR, BOOT_VECTOR);
  endtask : t_ext_boot

  // Pin reset with a bad backup supply, straps back to single-chip and plain vector
  task automatic t_ram_loss;
    wr(REG_CTRL, 32'h0000_0001);
    cpu_data_oe <= 1'b1;
    backup_supply_ok <= 1'b0;
    boot_mode_pin <= 1'b0;
    ext_mode_pin <= 1'b0;
    tick(3);
    chk(32'(data_pin_oe_q), 32'({DBUS_PINS{1'b1}}));
    chk(32'(ram_valid_q), 32'h0000_0001);
    chk(32'(port_in_en_q), 32'h0000_0001);
    @(posedge ref_clk);
    kick <= 1'b1;
    @(posedge ref_clk);
    kick <= 1'b0;
    wait_core(1'b0);
    tick(1);
    chk(32'(data_pin_oe_q), 32'h0000_0000);
    chk(32'(ram_valid_q), 32'h0000_0000);
    chk(32'(port_in_en_q), 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0001);
    rd(REG_STATUS, 32'h0000_0001);
    wait_core(1'b1);
    chk(pc_value_q, PLAIN_VECTOR);
    chk(32'(ram_valid_q), 32'h0000_0000);
    chk(32'(port_in_en_q), 32'h0000_0000);
    tick(3);
    chk(32'(data_pin_oe_q), 32'h0000_0000);
    chk(32'(addr_pin_oe_q), 32'h0000_0000);
  endtask : t_ram_loss

  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    tick(1);
    t_power();
    t_regs();
    t_ext_boot();
    t_ram_loss();
    stop_test();
  end

  // Whole run is under a hundred cycles
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
endmodule : mrs_reset_seq_tb

// ==== mrs_reset_src.sv ====
// Model of the outside reset source and clock multiplier beside the sequencer.
// Assumes the testbench pulses kick for one cycle to ask for a reset in mid-run.
`timescale 1ns/10ps
module mrs_reset_src #(
  parameter int LOCK_CYC = 30,
  parameter int PULSE_CYC = 6
) (
  // Clock
  input wire logic ref_clk,
  // Request from the bench
  input wire logic kick,
  // Toward the sequencer
  output logic reset_pin_n,
  output logic pll_locked
);
  initial begin
    reset_pin_n = 1'b0;
    pll_locked = 1'b0;
    repeat (LOCK_CYC) @(posedge ref_clk);
    pll_locked <= 1'b1;
    // Pin is let go only once the multiplier is stable
    @(posedge ref_clk);
    reset_pin_n <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (kick) begin
        // Kept low longer than four oscillator periods
        reset_pin_n <= 1'b0;
        repeat (PULSE_CYC) @(posedge ref_clk);
        reset_pin_n <= 1'b1;
      end
    end
  end
endmodule : mrs_reset_src

// ==== mrs_sync.sv ====
// Two-stage synchroniser for the chip reset pin.
// Assumes the pin is asynchronous to ref_clk; output is low while held in block reset.
`timescale 1ns/10ps
module mrs_sync
  import mrs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Pin and result
  input wire logic pin_n,
  output logic pin_sync_q
);
  logic meta_q;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      meta_q <= pin_n;
      pin_sync_q <= meta_q;
    end
  end

  sync_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !pin_n [*2] |=> !pin_sync_q)
    else $error("reset pin low not passed through in two cycles");
endmodule : mrs_sync
